//--- inc/stdc_defines.svh
// What this block does
// - In four-wire mode the driver and receiver enables both stay on regardless of anything else.
// - With no mode configured, four-wire operation is the mode in force.
// - In echo mode the driver is off while terminal-ready is unasserted and on only while asserted.
// - In echo mode the receiver stays enabled so the node hears its own bytes.
// - Terminal-ready is active low, so asserted means a low level.
// - In terminal-ready controlled mode the driver follows terminal-ready and the receiver is off while it drives.
// - In automatic mode the driver turns on by itself for every byte sent.
// - In automatic mode the receiver is off while driving and back on when nothing is sent.
// - Mode codes are 128 four-wire, 129 echo, 130 terminal-ready controlled, 131 automatic.
// - The stored mode takes effect when the port is opened.
`ifndef STDC_DEFINES_SVH
`define STDC_DEFINES_SVH
`define STDC_MODE_W        8
`define STDC_MODE_FOUR     8'h80
`define STDC_MODE_ECHO     8'h81
`define STDC_MODE_DTRCTL   8'h82
`define STDC_MODE_AUTO     8'h83
`endif

//--- inc/stdc_pkg.sv
package stdc_pkg;
  typedef enum logic [3:0] {
    STDC_FOUR   = 4'h1,
    STDC_ECHO   = 4'h2,
    STDC_DTRCTL = 4'h4,
    STDC_AUTO   = 4'h8
  } stdc_mode_t;
endpackage : stdc_pkg

//--- rtl/stdc_sync.sv
`timescale 1ns/1ps
module stdc_sync (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic d,
  output logic      q
);
  logic meta;
  // Reset high, the idle level of an active-low pin, so no false assert
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b1;
      q    <= 1'b1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : stdc_sync

//--- rtl/stdc_ctrl.sv
`timescale 1ns/1ps
`include "stdc_defines.svh"
module stdc_ctrl #(
  parameter int MODE_W = `STDC_MODE_W
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Configuration
  input  wire logic [MODE_W-1:0]       mode_cfg,
  input  wire logic                   mode_cfg_valid,
  input  wire logic                   port_open,
  // UART side
  input  wire logic                   dtr_n,
  input  wire logic                   tx_busy,
  // Line side
  output logic                        drv_en,
  output logic                        rcv_en,
  output logic [3:0]                  mode_active
);
  logic                    dtr_n_s;
  logic                    dtr_on;
  logic                    stored_valid;
  logic [MODE_W-1:0]       stored;
  logic                    open_q;
  logic                    open_rise;
  stdc_pkg::stdc_mode_t    mode;
  stdc_pkg::stdc_mode_t    next_mode;
  logic                    next_drv;
  logic                    next_rcv;

  // Mode codes need eight bits; a narrower selector would alias them
  if (MODE_W < `STDC_MODE_W) begin : g_mode_w_chk
    $error("mode selector narrower than the mode codes");
  end

  // Pin from the UART crosses in through two flops
  stdc_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        (dtr_n),
    .q        (dtr_n_s)
  );

  assign dtr_on = ~dtr_n_s;

  function automatic stdc_pkg::stdc_mode_t stdc_decode(input logic [MODE_W-1:0] c,
                                                       input logic v);
    if (!v) begin
      return stdc_pkg::STDC_FOUR;
    end
    case (c)
      `STDC_MODE_ECHO:   return stdc_pkg::STDC_ECHO;
      `STDC_MODE_DTRCTL: return stdc_pkg::STDC_DTRCTL;
      `STDC_MODE_AUTO:   return stdc_pkg::STDC_AUTO;
      default:           return stdc_pkg::STDC_FOUR;
    endcase
  endfunction : stdc_decode

  // Stored selection, latched whenever software supplies one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stored_valid <= 1'b0;
      stored       <= MODE_W'(`STDC_MODE_FOUR);
    end else if (mode_cfg_valid) begin
      stored_valid <= 1'b1;
      stored       <= mode_cfg;
    end
  end

  // Mode only changes on the rising edge of port_open, whether or not a frame is being sent
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      open_q <= 1'b0;
    end else begin
      open_q <= port_open;
    end
  end

  assign open_rise = port_open && !open_q;

  always_comb begin
    next_mode = mode;
    if (open_rise) begin
      next_mode = stdc_decode(stored, stored_valid);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= stdc_pkg::STDC_FOUR;
    end else begin
      mode <= next_mode;
    end
  end

  // tx_busy must cover through the final stop bit; no extra hold kept here
  always_comb begin
    next_drv = 1'b1;
    next_rcv = 1'b1;
    unique case (mode)
      stdc_pkg::STDC_FOUR: begin
        next_drv = 1'b1;
        next_rcv = 1'b1;
      end
      stdc_pkg::STDC_ECHO: begin
        next_drv = dtr_on;
        next_rcv = 1'b1;
      end
      stdc_pkg::STDC_DTRCTL: begin
        next_drv = dtr_on;
        next_rcv = ~dtr_on;
      end
      stdc_pkg::STDC_AUTO: begin
        next_drv = tx_busy;
        next_rcv = ~tx_busy;
      end
    endcase
  end

  // Registered so the line enables never glitch on a mode change
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_en <= 1'b1;
    end else begin
      drv_en <= next_drv;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcv_en <= 1'b1;
    end else begin
      rcv_en <= next_rcv;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_active <= stdc_pkg::STDC_FOUR;
    end else begin
      mode_active <= next_mode;
    end
  end

  // Enables in force, one cycle behind the mode
  four_wire_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode) == stdc_pkg::STDC_FOUR |-> drv_en && rcv_en)
    else $error("four-wire enables dropped");

  echo_drv_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode) == stdc_pkg::STDC_ECHO |-> drv_en == ~$past(dtr_n_s) && rcv_en)
    else $error("echo mode enables wrong");

  dtr_ctl_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode) == stdc_pkg::STDC_DTRCTL |-> drv_en != rcv_en && drv_en == ~$past(dtr_n_s))
    else $error("controlled mode enables wrong");

  ctl_pol_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode) == stdc_pkg::STDC_DTRCTL && $past(dtr_n_s) |-> !drv_en && rcv_en)
    else $error("unasserted terminal-ready left receiver off");

  dtr_pol_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode) == stdc_pkg::STDC_ECHO && !$past(dtr_n_s) |-> drv_en)
    else $error("low terminal-ready did not drive");

  auto_drv_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode) == stdc_pkg::STDC_AUTO |-> drv_en == $past(tx_busy))
    else $error("auto driver not following transmit");

  auto_rcv_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode) == stdc_pkg::STDC_AUTO |-> rcv_en == ~drv_en)
    else $error("auto receiver overlaps driver");

  auto_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode) == stdc_pkg::STDC_AUTO && !$past(tx_busy) |-> rcv_en && !drv_en)
    else $error("receiver not back after frame");

  auto_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == stdc_pkg::STDC_AUTO && tx_busy ##1 mode == stdc_pkg::STDC_AUTO |-> drv_en)
    else $error("driver released while busy");

  // Selection and decode
  open_only_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(port_open && !open_q) |=> $stable(mode))
    else $error("mode changed without open");

  mode_mirror_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_active == mode)
    else $error("reported mode differs from mode in force");

  mode_onehot_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $onehot(mode))
    else $error("mode in force not one-hot");

  store_take_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode_cfg_valid |=> stored_valid && stored == $past(mode_cfg))
    else $error("mode selection not stored");

  default_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    port_open && !open_q && !stored_valid |=> mode == stdc_pkg::STDC_FOUR)
    else $error("default mode not four-wire");

  auto_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    port_open && !open_q && stored_valid && stored == `STDC_MODE_AUTO
    |=> mode == stdc_pkg::STDC_AUTO)
    else $error("auto code not decoded");

  echo_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    open_rise && stored_valid && stored == `STDC_MODE_ECHO
    |=> mode == stdc_pkg::STDC_ECHO)
    else $error("echo code not decoded");

  ctl_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    open_rise && stored_valid && stored == `STDC_MODE_DTRCTL
    |=> mode == stdc_pkg::STDC_DTRCTL)
    else $error("controlled code not decoded");

  odd_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    open_rise && stored_valid && stored != `STDC_MODE_ECHO
    && stored != `STDC_MODE_DTRCTL && stored != `STDC_MODE_AUTO
    |=> mode == stdc_pkg::STDC_FOUR)
    else $error("other code not taken as four-wire");
endmodule : stdc_ctrl

//--- tb/stdc_uart_model.sv
`timescale 1ns/1ps
module stdc_uart_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Software requests
  input  wire logic dtr_on,
  input  wire logic start,
  // UART pins
  output logic      dtr_n,
  output logic      tx_busy
);
  logic [3:0] bit_cnt;
  // Low level means asserted
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) dtr_n <= 1'b1;
    else dtr_n <= ~dtr_on;
  end
  // Ten bit times with stop bit, so busy covers the whole frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) bit_cnt <= 4'h0;
    else if (start) bit_cnt <= 4'hA;
    else if (bit_cnt != 4'h0) bit_cnt <= bit_cnt - 4'h1;
  end
  assign tx_busy = (bit_cnt != 4'h0);
endmodule : stdc_uart_model

//--- tb/serial_transceiver_direction_control_tb.sv
`timescale 1ns/1ps
module serial_transceiver_direction_control_tb;
  logic       core_clk, rst_n, mode_cfg_valid, port_open, dtr_on, start;
  logic       dtr_n, tx_busy, drv_en, rcv_en;
  logic [7:0] mode_cfg;
  logic [3:0] mode_active;
  int         bad_count, cmp_count, cycles;
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Hang guard, far above the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end
  stdc_uart_model uart_u (.core_clk(core_clk), .rst_n(rst_n), .dtr_on(dtr_on),
    .start(start), .dtr_n(dtr_n), .tx_busy(tx_busy));
  stdc_ctrl dut_u (.core_clk(core_clk), .rst_n(rst_n), .mode_cfg(mode_cfg),
    .mode_cfg_valid(mode_cfg_valid), .port_open(port_open), .dtr_n(dtr_n),
    .tx_busy(tx_busy), .drv_en(drv_en), .rcv_en(rcv_en), .mode_active(mode_active));
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_n
  task automatic chk(input logic [5:0] exp);
    cmp_count++;
    if ({drv_en, rcv_en, mode_active} !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, {drv_en, rcv_en, mode_active}, exp);
    end
  endtask : chk
  task automatic open_mode(input logic [7:0] code);
    mode_cfg = code;
    mode_cfg_valid = 1'b1;
    wait_n(1);
    mode_cfg_valid = 1'b0;
    port_open = 1'b0;
    wait_n(1);
    port_open = 1'b1;
    wait_n(4);
  endtask : open_mode
  task automatic send(input int hold);
    start = 1'b1;
    wait_n(1);
    start = 1'b0;
    wait_n(hold);
  endtask : send
  task automatic run_four;
    chk(6'h31);
    open_mode(8'h80);
    dtr_on = 1'b1;
    send(4);
    chk(6'h31);
    dtr_on = 1'b0;
    mode_cfg = 8'h83;
    mode_cfg_valid = 1'b1;
    wait_n(1);
    mode_cfg_valid = 1'b0;
    wait_n(5);
    chk(6'h31);
  endtask : run_four
  task automatic run_keyed;
    open_mode(8'h81);
    wait_n(2);
    chk(6'h12);
    dtr_on = 1'b1;
    wait_n(5);
    chk(6'h32);
    open_mode(8'h82);
    send(4);
    chk(6'h24);
    wait_n(10);
    dtr_on = 1'b0;
    wait_n(5);
    chk(6'h14);
  endtask : run_keyed
  task automatic run_auto;
    open_mode(8'h83);
    chk(6'h18);
    send(3);
    chk(6'h28);
    wait_n(6);
    chk(6'h28);
    wait_n(1);
    chk(6'h28);
    wait_n(1);
    chk(6'h18);
    open_mode(8'h84);
    chk(6'h31);
  endtask : run_auto
  task automatic run_reset;
    open_mode(8'h83);
    chk(6'h18);
    rst_n = 1'b0;
    wait_n(1);
    chk(6'h31);
    rst_n = 1'b1;
    port_open = 1'b0;
    wait_n(2);
    port_open = 1'b1;
    wait_n(4);
    chk(6'h31);
  endtask : run_reset
  task automatic conclude;
    $display("mismatches=%0d compares=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    rst_n = 1'b0;
    mode_cfg = 8'h00;
    mode_cfg_valid = 1'b0;
    port_open = 1'b0;
    dtr_on = 1'b0;
    start = 1'b0;
    wait_n(6);
    rst_n = 1'b1;
    wait_n(1);
    run_four();
    run_keyed();
    run_auto();
    run_reset();
    conclude();
  end
endmodule : serial_transceiver_direction_control_tb
